// ===== ext_line_detect.sv
// Purpose: edge/level detector with request latch for one line
// Assumes: line already synchronised
// Notes:   low level mode adds the live low line to its falling-edge latch, edge modes latch only
`timescale 1ns/10ps
module ext_line_detect (
  // clock and reset
  input  wire logic mclk_in,
  input  wire logic reset_n_in,
  // carrier
  ext_line_if.det   lnk
);
  import irq_ctrl_pkg::*;

  logic line_d_ff;
  logic latch_ff;
  logic nxt_latch;
  logic fall_w;
  logic rise_w;
  logic edge_w;

  // edge decode on the ored line
  assign fall_w = line_d_ff & ~lnk.line;
  assign rise_w = ~line_d_ff & lnk.line;
  assign edge_w = (lnk.pol == POL_FALL_LOW || lnk.pol == POL_FALL) ? fall_w :
                  (lnk.pol == POL_RISE) ? rise_w : (fall_w | rise_w);
  // set wins over the acknowledge clear
  assign nxt_latch = edge_w | (latch_ff & ~lnk.ack);
  // low level mode requests while the line stays low
  assign lnk.req = latch_ff | ((lnk.pol == POL_FALL_LOW) & ~lnk.line);

  // line history and request latch
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      line_d_ff <= 1'b1;
      latch_ff  <= 1'b0;
    end else begin
      line_d_ff <= lnk.line;
      latch_ff  <= nxt_latch;
    end
  end

endmodule : ext_line_detect

// ===== ext_line_if.sv
// Purpose: carrier between controller and one external line detector
// Assumes: single clock domain
// Notes:   one instance per external line
`timescale 1ns/10ps
interface ext_line_if;
  logic       line;      // synchronised ored line
  logic [1:0] pol;       // polarity selection
  logic       ack;       // service entry clears latch
  logic       req;       // pending request
  modport ctrl (output line, output pol, output ack, input req);
  modport det  (input line, input pol, input ack, output req);
endinterface : ext_line_if

// ===== irq_controller.sv
// Purpose: interrupt controller and entry/return sequencer of the core
// Assumes: core signals instruction boundaries and trap/return strobes
// Notes:   stack bytes go out one per cycle on a push/pop port
`timescale 1ns/10ps
module irq_controller #(
  parameter int PERIPH_NUM = 4
) (
  // clock and reset
  input  wire logic                 mclk_in,
  input  wire logic                 reset_n_in,
  // port pins and their interrupt enables
  input  wire logic [3:0]           port_a_pin_in,
  input  wire logic [3:0]           port_a_irq_en_in,
  input  wire logic [2:0]           port_f_pin_in,
  input  wire logic [2:0]           port_f_irq_en_in,
  input  wire logic [7:0]           port_b_pin_in,
  input  wire logic [7:0]           port_b_irq_en_in,
  // polarity bits, order ext3 hi, ext2 lo, ext1 hi, ext0 lo pairs
  input  wire logic                 ext_irq3_polarity_hi_in,
  input  wire logic                 ext_irq2_polarity_lo_in,
  input  wire logic                 ext_irq1_polarity_hi_in,
  input  wire logic                 ext_irq0_polarity_lo_in,
  // peripherals: spi, timer a, timer b, sci
  input  wire logic [PERIPH_NUM-1:0] periph_flag_in,
  input  wire logic [PERIPH_NUM-1:0] periph_en_in,
  input  wire logic [PERIPH_NUM-1:0] periph_clear_seq_in,
  // core sequencer
  input  wire logic                 instr_end_in,
  input  wire logic                 trap_instr_in,
  input  wire logic                 return_from_irq_instr_in,
  input  wire logic                 wait_for_irq_instr_in,
  input  wire logic                 halt_instr_in,
  input  wire logic                 mask_set_in,
  input  wire logic                 mask_clear_in,
  input  wire logic [15:0]          program_counter_in,
  input  wire logic [7:0]           index_in,
  input  wire logic [7:0]           accum_in,
  input  wire logic [7:0]           condition_code_reg_in,
  input  wire logic [7:0]           stack_rd_data_in,
  // outputs to core
  output logic                      irq_mask_out,
  output logic                      core_stall_out,
  output logic                      stack_wr_out,
  output logic                      stack_rd_out,
  output logic [15:0]               stack_addr_out,
  output logic [7:0]                stack_wr_data_out,
  output logic                      pc_load_out,
  output logic [15:0]               pc_load_value_out,
  output logic                      ctx_restore_out,
  output logic [7:0]                restored_cc_out,
  output logic [7:0]                restored_x_out,
  output logic [7:0]                restored_a_out,
  output logic [15:0]               restored_pc_out,
  output logic [SRC_NUM-1:0]        pending_out,
  output logic                      in_wait_out,
  output logic                      in_halt_out
);
  import irq_ctrl_pkg::*;

  initial begin
    if (PERIPH_NUM != 4) $error("four peripheral blocks only");
  end

  localparam int MASK_BIT = 3;

  // ---------------------------------------------------------------
  // pin synchronisers and group or
  // ---------------------------------------------------------------
  logic [14:0] pin_meta_ff;
  logic [14:0] pin_sync_ff;
  logic [14:0] pin_en_w;
  logic [3:0]  ext_line_w;
  logic [1:0]  pol_w [4];
  logic [3:0]  ext_req_w;
  logic [3:0]  ext_ack_w;

  assign pin_en_w = {port_b_irq_en_in, port_f_irq_en_in, port_a_irq_en_in};

  // two flops per pin before any logic
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_meta_ff <= 15'h7fff;
      pin_sync_ff <= 15'h7fff;
    end else begin
      pin_meta_ff <= {port_b_pin_in, port_f_pin_in, port_a_pin_in};
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // and-combine: an enabled pin held low pulls the line low
  function automatic logic group_line(input logic [7:0] pins, input logic [7:0] ens);
    group_line = &(pins | ~ens);
  endfunction : group_line

  // ored group lines, low active event lines
  assign ext_line_w[0] = group_line({4'hf, pin_sync_ff[3:0]},   {4'h0, pin_en_w[3:0]});
  assign ext_line_w[1] = group_line({5'h1f, pin_sync_ff[6:4]},  {5'h00, pin_en_w[6:4]});
  assign ext_line_w[2] = group_line({4'hf, pin_sync_ff[10:7]},  {4'h0, pin_en_w[10:7]});
  assign ext_line_w[3] = group_line({4'hf, pin_sync_ff[14:11]}, {4'h0, pin_en_w[14:11]});

  // polarity pairs, hi bit first
  assign pol_w[0] = {ext_irq1_polarity_hi_in, ext_irq0_polarity_lo_in};
  assign pol_w[1] = pol_w[0];
  assign pol_w[2] = {ext_irq3_polarity_hi_in, ext_irq2_polarity_lo_in};
  assign pol_w[3] = pol_w[2];

  // one detector per external line
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_ext
      ext_line_if lnk_i ();
      assign lnk_i.line = ext_line_w[gi];
      assign lnk_i.pol  = pol_w[gi];
      assign lnk_i.ack  = ext_ack_w[gi];
      assign ext_req_w[gi] = lnk_i.req;
      ext_line_detect u_det (
        .mclk_in    (mclk_in),
        .reset_n_in (reset_n_in),
        .lnk        (lnk_i.det)
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // peripheral pending latches
  // ---------------------------------------------------------------
  logic [PERIPH_NUM-1:0] per_pend_ff;
  logic [PERIPH_NUM-1:0] nxt_per_pend;

  // flag latched; clear sequence or flag drop discards, a live flag wins
  assign nxt_per_pend = periph_flag_in & (per_pend_ff | periph_flag_in)
                        & ~(periph_clear_seq_in & ~periph_flag_in);

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      per_pend_ff <= '0;
    end else begin
      per_pend_ff <= nxt_per_pend;
    end
  end

  // ---------------------------------------------------------------
  // priority resolution
  // ---------------------------------------------------------------
  logic                 mask_ff;
  logic [SRC_NUM-1:0]   pend_w;
  logic [SRC_NUM-1:0]   serv_w;
  logic [SRC_NUM-1:0]   sel_w;
  logic                 any_serv_w;
  logic                 halt_wake_w;
  logic [15:0]          sel_vec_w;

  assign pend_w = {per_pend_ff, ext_req_w, trap_instr_in, 1'b0};
  // maskable sources need the mask clear, peripherals also their enable
  assign serv_w = {per_pend_ff & periph_en_in & {PERIPH_NUM{~mask_ff}},
                   ext_req_w & {4{~mask_ff}},
                   trap_instr_in, 1'b0};
  assign sel_w      = serv_w & (~serv_w + 10'h001);   // lowest index wins
  assign any_serv_w = |serv_w;
  assign halt_wake_w = |ext_req_w;

  // vector lookup by one-hot selection
  function automatic logic [15:0] vec_of(input logic [SRC_NUM-1:0] s);
    vec_of = VEC_RESET;
    if (s[SRC_TRAP]) vec_of = VEC_TRAP;
    if (s[SRC_EXT0]) vec_of = VEC_EXT0;
    if (s[SRC_EXT1]) vec_of = VEC_EXT1;
    if (s[SRC_EXT2]) vec_of = VEC_EXT2;
    if (s[SRC_EXT3]) vec_of = VEC_EXT3;
    if (s[SRC_SPI])  vec_of = VEC_SPI;
    if (s[SRC_TIMA]) vec_of = VEC_TIMA;
    if (s[SRC_TIMB]) vec_of = VEC_TIMB;
    if (s[SRC_SCI])  vec_of = VEC_SCI;
  endfunction : vec_of

  assign sel_vec_w = vec_of(sel_w);

  // ---------------------------------------------------------------
  // entry / return sequencer
  // ---------------------------------------------------------------
  seq_state_t     state_ff;
  seq_state_t     nxt_state;
  logic [2:0]     cnt_ff;
  logic [7:0]     sp_ff;
  logic [15:0]    vec_ff;
  logic [3:0]     ack_ff;
  logic [7:0]     ctx_ff [STACK_BYTES];
  logic [7:0]     rest_ff [STACK_BYTES];
  logic           restore_ff;
  logic [2:0]     cnt_last;
  logic           take_w;
  logic           boundary_w;

  assign cnt_last   = 3'(STACK_BYTES - 1);
  assign boundary_w = instr_end_in & (state_ff == ST_RUN);
  assign take_w     = any_serv_w & (boundary_w | state_ff == ST_WAIT |
                                    (state_ff == ST_HALT & halt_wake_w));
  assign ext_ack_w  = ack_ff;

  // next state
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_RUN: begin
        if (take_w) nxt_state = ST_PUSH;
        else if (return_from_irq_instr_in) nxt_state = ST_POP;
        else if (wait_for_irq_instr_in) nxt_state = ST_WAIT;
        else if (halt_instr_in) nxt_state = ST_HALT;
      end
      ST_PUSH:   if (cnt_ff == cnt_last) nxt_state = ST_VECTOR;
      ST_VECTOR: nxt_state = ST_RUN;
      ST_POP:    if (cnt_ff == cnt_last) nxt_state = ST_RUN;
      ST_WAIT:   if (take_w) nxt_state = ST_PUSH;
      ST_HALT:   if (take_w) nxt_state = ST_PUSH;
    endcase
  end

  // state, counter, stack pointer
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_ff <= ST_RUN;
      cnt_ff   <= 3'h0;
      sp_ff    <= SP_RESET;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= (nxt_state != state_ff) ? 3'h0 : 3'(cnt_ff + 3'h1);
      if (state_ff == ST_PUSH) sp_ff <= 8'(sp_ff - 8'h01);
      else if (nxt_state == ST_POP || (state_ff == ST_POP && cnt_ff != cnt_last))
        sp_ff <= 8'(sp_ff + 8'h01);
    end
  end

  // context capture at entry, vector latch and latch acknowledge
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      vec_ff <= VEC_RESET;
      ack_ff <= 4'h0;
      for (int i = 0; i < STACK_BYTES; i++) ctx_ff[i] <= 8'h00;
    end else begin
      ack_ff <= take_w ? sel_w[SRC_EXT3:SRC_EXT0] : 4'h0;
      if (take_w) begin
        vec_ff    <= sel_vec_w;
        ctx_ff[0] <= program_counter_in[7:0];
        ctx_ff[1] <= program_counter_in[15:8];
        ctx_ff[2] <= index_in;
        ctx_ff[3] <= accum_in;
        ctx_ff[4] <= condition_code_reg_in;
      end
    end
  end

  // popped bytes arrive in reverse order
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < STACK_BYTES; i++) rest_ff[i] <= 8'h00;
      restore_ff <= 1'b0;
    end else begin
      if (state_ff == ST_POP) rest_ff[cnt_last - cnt_ff] <= stack_rd_data_in;
      restore_ff <= (state_ff == ST_POP) & (cnt_ff == cnt_last);
    end
  end

  // global mask bit: entry sets, return restores, wait/halt clear
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mask_ff <= 1'b1;
    end else if (state_ff == ST_VECTOR) begin
      mask_ff <= 1'b1;
    end else if (restore_ff) begin
      mask_ff <= rest_ff[4][MASK_BIT];
    end else if (nxt_state == ST_WAIT || nxt_state == ST_HALT) begin
      mask_ff <= 1'b0;
    end else if (mask_set_in) begin
      mask_ff <= 1'b1;
    end else if (mask_clear_in) begin
      mask_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign irq_mask_out      = mask_ff;
  assign core_stall_out    = (state_ff != ST_RUN) | restore_ff;
  assign stack_wr_out      = (state_ff == ST_PUSH);
  assign stack_rd_out      = (state_ff == ST_POP);
  assign stack_addr_out    = {8'h01, sp_ff};
  assign stack_wr_data_out = ctx_ff[cnt_ff];
  assign pc_load_out       = (state_ff == ST_VECTOR);
  assign pc_load_value_out = vec_ff;
  assign ctx_restore_out   = restore_ff;
  assign restored_pc_out   = {rest_ff[1], rest_ff[0]};
  assign restored_x_out    = rest_ff[2];
  assign restored_a_out    = rest_ff[3];
  assign restored_cc_out   = rest_ff[4];
  assign pending_out       = pend_w;
  assign in_wait_out       = (state_ff == ST_WAIT);
  assign in_halt_out       = (state_ff == ST_HALT);


endmodule : irq_controller

// ===== irq_ctrl_checker.sv
// Purpose: concurrent checks on the interrupt controller ports
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound to every irq_controller instance
`timescale 1ns/10ps
module irq_ctrl_checker (
  // clock and reset
  input wire logic                              mclk_in,
  input wire logic                              reset_n_in,
  // core strobes
  input wire logic                              instr_end_in,
  input wire logic                              trap_instr_in,
  // controller outputs
  input wire logic                              irq_mask_out,
  input wire logic                              stack_wr_out,
  input wire logic                              stack_rd_out,
  input wire logic [15:0]                       stack_addr_out,
  input wire logic                              pc_load_out,
  input wire logic                              ctx_restore_out,
  input wire logic [7:0]                        restored_cc_out,
  input wire logic [irq_ctrl_pkg::SRC_NUM-1:0]  pending_out,
  input wire logic                              in_wait_out,
  input wire logic                              in_halt_out
);
  import irq_ctrl_pkg::*;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  // sequencer sits in run with no transfer under way
  wire run_idle = !stack_wr_out && !stack_rd_out && !pc_load_out && !ctx_restore_out && !in_wait_out && !in_halt_out;
  // ---------------------------------------------------------------
  // entry and return steps
  // ---------------------------------------------------------------
  sequence s_push;
    stack_wr_out [*5] ##1 (!stack_wr_out && pc_load_out);
  endsequence
  sequence s_pop;
    stack_rd_out [*5] ##1 (!stack_rd_out && ctx_restore_out);
  endsequence
  property p_push_len; $rose(stack_wr_out) |-> s_push; endproperty
  property p_mask_entry; pc_load_out |=> irq_mask_out; endproperty
  property p_sp_dec; stack_wr_out && $past(stack_wr_out) |-> stack_addr_out == $past(stack_addr_out) - 16'h1;
  endproperty
  property p_page; (stack_wr_out || stack_rd_out) |-> stack_addr_out[15:8] == 8'h01; endproperty
  property p_pop_len; $rose(stack_rd_out) |-> s_pop; endproperty
  property p_pop_inc; stack_rd_out && $past(stack_rd_out) |-> stack_addr_out == $past(stack_addr_out) + 16'h1;
  endproperty
  property p_restore_mask; ctx_restore_out |-> ##[0:1] (irq_mask_out == restored_cc_out[3]); endproperty
  property p_mask_gate; (irq_mask_out && !trap_instr_in && instr_end_in && run_idle) |=> !stack_wr_out; endproperty
  property p_trap; (trap_instr_in && instr_end_in && run_idle) |=> stack_wr_out; endproperty
  property p_halt_hold; (in_halt_out && !(|pending_out[SRC_EXT3:SRC_EXT0])) |=> in_halt_out; endproperty
  a_push_len: assert property (p_push_len) else $error("push length");
  a_mask_entry: assert property (p_mask_entry) else $error("entry mask");
  a_sp_dec: assert property (p_sp_dec) else $error("push address");
  a_page: assert property (p_page) else $error("stack page wrong");
  a_pop_len: assert property (p_pop_len) else $error("pop length");
  a_pop_inc: assert property (p_pop_inc) else $error("pop address");
  a_restore_mask: assert property (p_restore_mask) else $error("mask not restored");
  a_mask_gate: assert property (p_mask_gate) else $error("entry while masked");
  a_trap: assert property (p_trap) else $error("trap not entered");
  a_halt_hold: assert property (p_halt_hold) else $error("halt left early");
endmodule : irq_ctrl_checker

bind irq_controller irq_ctrl_checker u_irq_ctrl_checker (
  .mclk_in, .reset_n_in, .instr_end_in, .trap_instr_in, .irq_mask_out, .stack_wr_out, .stack_rd_out,
  .stack_addr_out, .pc_load_out, .ctx_restore_out, .restored_cc_out, .pending_out, .in_wait_out, .in_halt_out
);

// ===== irq_ctrl_pkg.sv
// Purpose: shared constants for the interrupt controller
// Assumes: 8-bit core, 16-bit vector addresses
// Notes:   vectors are the low address of each pair
package irq_ctrl_pkg;

  // ---------------------------------------------------------------
  // source indices, highest priority first
  // ---------------------------------------------------------------
  localparam int SRC_NUM    = 10;
  localparam int SRC_RESET  = 0;
  localparam int SRC_TRAP   = 1;
  localparam int SRC_EXT0   = 2;
  localparam int SRC_EXT1   = 3;
  localparam int SRC_EXT2   = 4;
  localparam int SRC_EXT3   = 5;
  localparam int SRC_SPI    = 6;
  localparam int SRC_TIMA   = 7;
  localparam int SRC_TIMB   = 8;
  localparam int SRC_SCI    = 9;

  // ---------------------------------------------------------------
  // vector addresses
  // ---------------------------------------------------------------
  localparam logic [15:0] VEC_RESET = 16'hfffe;
  localparam logic [15:0] VEC_TRAP  = 16'hfffc;
  localparam logic [15:0] VEC_EXT0  = 16'hfff6;
  localparam logic [15:0] VEC_EXT1  = 16'hfff4;
  localparam logic [15:0] VEC_EXT2  = 16'hfff2;
  localparam logic [15:0] VEC_EXT3  = 16'hfff0;
  localparam logic [15:0] VEC_SPI   = 16'hffec;
  localparam logic [15:0] VEC_TIMA  = 16'hffea;
  localparam logic [15:0] VEC_TIMB  = 16'hffe8;
  localparam logic [15:0] VEC_SCI   = 16'hffe6;

  // ---------------------------------------------------------------
  // stacking, polarity codes, reset values
  // ---------------------------------------------------------------
  localparam int          STACK_BYTES = 5;
  localparam logic [7:0]  SP_RESET    = 8'hff;
  localparam logic [1:0]  POL_FALL_LOW = 2'h0;
  localparam logic [1:0]  POL_FALL     = 2'h2;
  localparam logic [1:0]  POL_RISE     = 2'h1;
  localparam logic [1:0]  POL_BOTH     = 2'h3;

  // sequencer states
  typedef enum logic [2:0] {
    ST_RUN, ST_PUSH, ST_VECTOR, ST_POP, ST_WAIT, ST_HALT
  } seq_state_t;

endpackage : irq_ctrl_pkg

// ===== mcu_interrupt_controller_test.sv
// Purpose: directed test of the interrupt controller
// Assumes: stack memory model on the core side
// Notes:   pins idle high, edges need three clocks to be seen
`timescale 1ns/10ps
module mcu_interrupt_controller_test;
  import irq_ctrl_pkg::*;
  localparam logic [7:0] XV = 8'h56;
  localparam logic [7:0] AV = 8'h78;
  logic        mclk_in, reset_n_in, instr_end_in, trap_instr_in, return_from_irq_instr_in;
  logic        wait_for_irq_instr_in, halt_instr_in, mask_set_in, mask_clear_in;
  logic [5:0]  stb;
  logic        core_stall_out;
  logic [14:0] pins, pin_en;                    // {port b, port f, port a}
  logic [3:0]  pol, periph_flag_in, periph_en_in, periph_clear_seq_in;
  logic [15:0] program_counter_in, pc_exp;
  logic [7:0]  condition_code_reg_in, stack_rd_data_in, cc_exp;
  logic        irq_mask_out, stack_wr_out, stack_rd_out, pc_load_out, ctx_restore_out, in_wait_out, in_halt_out;
  logic [15:0] stack_addr_out, pc_load_value_out, restored_pc_out;
  logic [7:0]  stack_wr_data_out, restored_cc_out, restored_x_out, restored_a_out;
  logic [SRC_NUM-1:0] pending_out;
  int          n_errors = 0;
  int          checks_done = 0;
  logic [15:0] vext [4] = '{VEC_EXT0, VEC_EXT1, VEC_EXT2, VEC_EXT3};
  logic [15:0] vper [4] = '{VEC_SPI, VEC_TIMA, VEC_TIMB, VEC_SCI};
  int          pin_of [4] = '{0, 4, 7, 11};
  // core condition code carries the live mask bit
  assign condition_code_reg_in = {4'h6, irq_mask_out, 3'h5};
  // one-hot core strobes
  assign {mask_clear_in, mask_set_in, halt_instr_in, wait_for_irq_instr_in, return_from_irq_instr_in,
          instr_end_in} = stb;
  irq_controller #(.PERIPH_NUM(4)) u_irq_controller (
    .mclk_in, .reset_n_in, .port_a_pin_in(pins[3:0]), .port_a_irq_en_in(pin_en[3:0]),
    .port_f_pin_in(pins[6:4]), .port_f_irq_en_in(pin_en[6:4]), .port_b_pin_in(pins[14:7]),
    .port_b_irq_en_in(pin_en[14:7]), .ext_irq3_polarity_hi_in(pol[3]), .ext_irq2_polarity_lo_in(pol[2]),
    .ext_irq1_polarity_hi_in(pol[1]), .ext_irq0_polarity_lo_in(pol[0]), .periph_flag_in, .periph_en_in,
    .periph_clear_seq_in, .instr_end_in, .trap_instr_in, .return_from_irq_instr_in, .wait_for_irq_instr_in,
    .halt_instr_in, .mask_set_in, .mask_clear_in, .program_counter_in, .index_in(XV), .accum_in(AV),
    .condition_code_reg_in, .stack_rd_data_in, .irq_mask_out, .core_stall_out, .stack_wr_out, .stack_rd_out,
    .stack_addr_out, .stack_wr_data_out, .pc_load_out, .pc_load_value_out, .ctx_restore_out, .restored_cc_out,
    .restored_x_out, .restored_a_out, .restored_pc_out, .pending_out, .in_wait_out, .in_halt_out);
  stack_ram_model u_stack_ram_model (.mclk_in, .stack_wr_in(stack_wr_out), .stack_rd_in(stack_rd_out),
    .stack_addr_in(stack_addr_out), .wr_data_in(stack_wr_data_out), .rd_data_out(stack_rd_data_in));
  // 25 mhz clock
  initial begin
    mclk_in = 1'b0;
    forever #20 mclk_in = ~mclk_in;
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  // one-cycle core strobe: 0 boundary 1 return 2 wait 3 halt 4 mask set 5 mask clear
  task automatic strobe(input int k);
    @(posedge mclk_in);
    stb <= 6'(1 << k);
    @(posedge mclk_in);
    stb <= 6'h0;
  endtask : strobe
  task automatic pin_to(input int p, input logic v);
    @(posedge mclk_in);
    pins[p] <= v;
    repeat (5) @(negedge mclk_in);
  endtask : pin_to
  task automatic bump;
    @(posedge mclk_in);
    program_counter_in <= program_counter_in + 16'h0111;
    @(negedge mclk_in);
  endtask : bump
  task automatic no_entry;
    logic seen = 1'b0;
    strobe(0);
    repeat (8) begin
      @(negedge mclk_in);
      seen |= stack_wr_out;
    end
    check(16'(seen), 16'h0);
  endtask : no_entry
  // entry: optional boundary, then vector, stacked bytes and mask
  task automatic enter(input logic [15:0] vec, input logic bnd);
    if (bnd) bump();
    pc_exp = program_counter_in;
    cc_exp = condition_code_reg_in;
    if (bnd) strobe(0);
    for (int n = 0; n < 40 && pc_load_out !== 1'b1; n++) @(negedge mclk_in);
    check(pc_load_value_out, vec);
    check(16'(core_stall_out), 16'h1);
    check({u_stack_ram_model.mem[8'hff], u_stack_ram_model.mem[8'hfe]}, {pc_exp[7:0], pc_exp[15:8]});
    check({u_stack_ram_model.mem[8'hfd], u_stack_ram_model.mem[8'hfc]}, {XV, AV});
    check(16'(u_stack_ram_model.mem[8'hfb]), 16'(cc_exp));
    @(negedge mclk_in);
    check(16'(irq_mask_out), 16'h1);
  endtask : enter
  task automatic leave;
    strobe(1);
    for (int n = 0; n < 20 && ctx_restore_out !== 1'b1; n++) @(negedge mclk_in);
    check(restored_pc_out, pc_exp);
    check({restored_x_out, restored_a_out}, {XV, AV});
    check(16'(restored_cc_out), 16'(cc_exp));
    @(negedge mclk_in);
    check(16'(irq_mask_out), 16'(cc_exp[3]));
  endtask : leave
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    reset_n_in = 1'b0;
    {stb, trap_instr_in} = 7'h0;
    pins = '1;
    pin_en = '0;
    pol = 4'b1010;
    {periph_flag_in, periph_en_in, periph_clear_seq_in} = '0;
    program_counter_in = 16'h1000;
    repeat (20) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    @(negedge mclk_in);
    check(16'(irq_mask_out), 16'h1);
    check(16'(pending_out), 16'h0);
    // each external line: edge latched under mask, taken after clear
    for (int i = 0; i < 4; i++) begin
      strobe(4);
      pin_en <= 15'(1 << pin_of[i]);
      pin_to(pin_of[i], 1'b0);
      pin_to(pin_of[i], 1'b1);
      check(16'(pending_out[SRC_EXT0 + i]), 16'h1);
      no_entry();
      strobe(5);
      enter(vext[i], 1'b1);
      check(16'(pending_out[SRC_EXT0 + i]), 16'h0);
      leave();
    end
    // two lines and a peripheral pending together
    @(posedge mclk_in);
    pin_en <= 15'h0810;
    {periph_flag_in[3], periph_en_in[3]} <= 2'b11;
    pin_to(4, 1'b0);
    pin_to(11, 1'b0);
    enter(VEC_EXT1, 1'b1);
    leave();
    enter(VEC_EXT3, 1'b1);
    pins <= '1;
    leave();
    enter(VEC_SCI, 1'b1);
    periph_flag_in[3] <= 1'b0;
    leave();
    // trap with mask set, then trap beating a pending peripheral
    for (int k = 0; k < 2; k++) begin
      strobe(4 + k);
      {periph_flag_in[0], periph_en_in[0]} <= 2'b11;
      trap_instr_in <= 1'b1;
      enter(VEC_TRAP, 1'b1);
      @(posedge mclk_in);
      trap_instr_in <= 1'b0;
      leave();
    end
    enter(VEC_SPI, 1'b1);
    {periph_flag_in, periph_en_in} <= '0;
    leave();
    // peripherals: held while disabled, dropped by clear sequence
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk_in);
      periph_flag_in[i] <= 1'b1;
      no_entry();
      check(16'(pending_out[SRC_SPI + i]), 16'h1);
      @(posedge mclk_in);
      {periph_flag_in[i], periph_clear_seq_in[i]} <= 2'b01;
      @(posedge mclk_in);
      {periph_clear_seq_in[i], periph_en_in[i]} <= 2'b01;
      no_entry();
      @(posedge mclk_in);
      periph_flag_in[i] <= 1'b1;
      enter(vper[i], 1'b1);
      {periph_flag_in, periph_en_in} <= '0;
      leave();
    end
    // halt ignores a peripheral, an external line ends it
    @(posedge mclk_in);
    pin_en <= 15'h0001;
    strobe(3);
    {periph_flag_in[1], periph_en_in[1]} <= 2'b11;
    repeat (10) @(negedge mclk_in);
    check(16'(in_halt_out), 16'h1);
    bump();
    @(posedge mclk_in);
    pins[0] <= 1'b0;
    enter(VEC_EXT0, 1'b0);
    {periph_flag_in, periph_en_in} <= '0;
    pins <= '1;
    leave();
    // wait ends on a peripheral request
    bump();
    strobe(2);
    @(negedge mclk_in);
    check(16'(in_wait_out), 16'h1);
    @(posedge mclk_in);
    {periph_flag_in[2], periph_en_in[2]} <= 2'b11;
    enter(VEC_TIMB, 1'b0);
    {periph_flag_in, periph_en_in} <= '0;
    leave();
    // rising sensitivity on an ored line held low by a second pin
    @(posedge mclk_in);
    pol <= 4'b0110;
    pin_en <= 15'h0180;
    pins[7] <= 1'b0;
    pin_to(8, 1'b0);
    pin_to(8, 1'b1);
    check(16'(pending_out[SRC_EXT2]), 16'h0);
    pin_to(7, 1'b1);
    check(16'(pending_out[SRC_EXT2]), 16'h1);
    enter(VEC_EXT2, 1'b1);
    leave();
    stop_test();
  end
  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge mclk_in);
    n_errors++;
    stop_test();
  end
endmodule : mcu_interrupt_controller_test

// ===== stack_ram_model.sv
// Purpose: stack memory of the core beside the controller
// Assumes: one byte a cycle, page fixed by the controller
// Notes:   outside pops the read bus shows the inverse of the last byte
`timescale 1ns/10ps
module stack_ram_model (
  // clock
  input  wire logic        mclk_in,
  // stack port
  input  wire logic        stack_wr_in,
  input  wire logic        stack_rd_in,
  input  wire logic [15:0] stack_addr_in,
  input  wire logic [7:0]  wr_data_in,
  output logic      [7:0]  rd_data_out
);
  logic [7:0] mem [256];
  logic [7:0] last_ff;
  initial last_ff = 8'h5a;
  // store pushed bytes, remember the last popped one
  always @(posedge mclk_in) begin
    if (stack_wr_in) mem[stack_addr_in[7:0]] <= wr_data_in;
    if (stack_rd_in) last_ff <= mem[stack_addr_in[7:0]];
  end
  // read data valid only while popping
  assign rd_data_out = stack_rd_in ? mem[stack_addr_in[7:0]] : ~last_ff;
endmodule : stack_ram_model
